// ---- hw/eau_unit.sv ----
// Effective address unit: mode decode, base select, indirection and timing.
//
// Overview of operation
// - Address part is 11 bits: three mode flags and an 8-bit signed displacement.
// - Post-offset flag is bit 10, deref flag bit 9, pre-offset flag bit 8.
// - Displacement is bits 0-7, signed, relative to the chosen base.
// - All flags clear: address is instruction counter plus displacement.
// - Displacement range is -128 to +127 only.
// - Deref reads memory at intermediate address; its 16 bits become the address.
// - Pre-offset uses common area register as base, before any indirection.
// - Post-offset adds stepping register after any indirection.
// - Pre-offset alone: common area register plus displacement, accessed directly.
// - Offsets add no time; indirection adds 0.9 us.
// - Special jump, byte and block instructions bypass this scheme.
// - Bits numbered 0 to 15, bit 15 most significant.
`timescale 1ns/1ns
module eau_unit
    import eau_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [15:0] instrWord,
    input wire logic ownFormat,
    input wire logic [15:0] instrCounter,
    input wire logic [15:0] commonAreaReg,
    input wire logic [15:0] steppingReg,
    output logic memReq,
    output logic [15:0] memAddr,
    input wire logic memAck,
    input wire logic [15:0] memData,
    output logic busy,
    output logic done,
    output logic [15:0] effAddr,
    output logic [4:0] extraCycles,
    output logic bypassed
);
    typedef struct packed {
        eau_state_t state;
        logic post;
        logic [15:0] stepping;
        logic [15:0] interAddr;
        logic [4:0] waitCnt;
        logic done;
        logic bypassed;
        logic [15:0] effAddr;
        logic [4:0] extra;
        logic [4:0] ackAge;
    } eau_regs_t;

    eau_regs_t r;
    eau_regs_t next_r;

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic postFlag;
    logic derefFlag;
    logic preFlag;
    logic [15:0] dispExt;
    logic [15:0] base;
    logic [15:0] interSum;
    logic [15:0] directSum;
    logic [15:0] derefSum;

    always_comb begin
        postFlag = instrWord[POST_OFFSET_BIT];
        derefFlag = instrWord[DEREF_BIT];
        preFlag = instrWord[PRE_OFFSET_BIT];
        // Sign extension confines reach to -128..+127 of the base
        dispExt = {{(WORD_W - DISP_W){instrWord[DISP_MSB]}},
            instrWord[DISP_MSB:DISP_LSB]};
        base = preFlag ? commonAreaReg : instrCounter;
    end

    // Intermediate address: base plus displacement, pre-offset applied first
    eau_adder uInter (
        .termA(base),
        .termB(dispExt),
        .termC(WORD_RESET),
        .sum(interSum)
    );

    // Direct path also adds the stepping register when post-offset is set
    eau_adder uDirect (
        .termA(base),
        .termB(dispExt),
        .termC(postFlag ? steppingReg : WORD_RESET),
        .sum(directSum)
    );

    // Fetched pointer gets only the optional post offset
    eau_adder uDeref (
        .termA(memData),
        .termB(r.post ? r.stepping : WORD_RESET),
        .termC(WORD_RESET),
        .sum(derefSum)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencing

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        // Checker helper: cycles since the pointer fetch, clearing to zero past the stall
        if (memReq && memAck) begin
            next_r.ackAge = 5'h01;
        end else if (r.ackAge != 5'h00 && r.ackAge <= DEREF_EXTRA_CYC_W) begin
            next_r.ackAge = r.ackAge + 5'h01;
        end else begin
            next_r.ackAge = 5'h00;
        end
        unique case (r.state)
            EAU_IDLE: begin
                if (start) begin
                    next_r.bypassed = ownFormat;
                    if (ownFormat) begin
                        next_r.done = 1'b1;
                        next_r.extra = 5'h00;
                    end else if (derefFlag) begin
                        next_r.state = EAU_FETCH;
                        next_r.interAddr = interSum;
                        next_r.post = postFlag;
                        next_r.stepping = steppingReg;
                    end else begin
                        // No time penalty without indirection
                        next_r.effAddr = directSum;
                        next_r.extra = 5'h00;
                        next_r.done = 1'b1;
                    end
                end
            end
            EAU_FETCH: begin
                if (memAck) begin
                    // Single level: the word fetched is never dereferenced again
                    next_r.effAddr = derefSum;
                    next_r.state = EAU_WAIT;
                    next_r.waitCnt = 5'h00;
                end
            end
            EAU_WAIT: begin
                // Stretch so the indirect path costs the listed extra time
                if (r.waitCnt >= DEREF_EXTRA_CYC_W - 5'h01) begin
                    next_r.state = EAU_IDLE;
                    next_r.extra = DEREF_EXTRA_CYC_W;
                    next_r.done = 1'b1;
                end else begin
                    next_r.waitCnt = r.waitCnt + 5'h01;
                end
            end
            default: next_r.state = EAU_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            r <= '{state: EAU_IDLE, post: 1'b0, stepping: WORD_RESET,
                interAddr: WORD_RESET, waitCnt: 5'h00, done: 1'b0,
                bypassed: 1'b0, effAddr: WORD_RESET, extra: 5'h00, ackAge: 5'h00};
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        memReq = (r.state == EAU_FETCH);
        memAddr = r.interAddr;
        busy = (r.state != EAU_IDLE);
        done = r.done;
        effAddr = r.effAddr;
        extraCycles = r.extra;
        bypassed = r.bypassed;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_DIRECT_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.state == EAU_IDLE && start && !ownFormat && !derefFlag) |=> done && !busy)
        else $error("direct access not finished in one cycle");
    AST_PC_REL: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.state == EAU_IDLE && start && !ownFormat && instrWord[10:8] == 3'b000)
        |=> effAddr == $past(instrCounter) + {{8{$past(instrWord[7])}}, $past(instrWord[7:0])})
        else $error("counter-relative address wrong");
    AST_PRE_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.state == EAU_IDLE && start && !ownFormat && instrWord[10:8] == 3'b001)
        |=> effAddr == $past(commonAreaReg) + {{8{$past(instrWord[7])}}, $past(instrWord[7:0])})
        else $error("pre-offset address wrong");
    AST_PRE_POST: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.state == EAU_IDLE && start && !ownFormat && instrWord[10:8] == 3'b101)
        |=> effAddr == $past(commonAreaReg) + $past(steppingReg)
            + {{8{$past(instrWord[7])}}, $past(instrWord[7:0])})
        else $error("pre plus post offset address wrong");
    AST_FETCH_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.state == EAU_IDLE && start && !ownFormat && instrWord[9])
        |=> memReq && memAddr == ($past(instrWord[8]) ? $past(commonAreaReg)
            : $past(instrCounter)) + {{8{$past(instrWord[7])}}, $past(instrWord[7:0])})
        else $error("intermediate address wrong");
    AST_DEREF_RESULT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (memReq && memAck) |=> effAddr == $past(memData) + ($past(r.post)
            ? $past(r.stepping) : 16'h0000))
        else $error("indirect address wrong");
    AST_DEREF_TIME: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.ackAge == DEREF_EXTRA_CYC_W + 5'h01) |-> done && extraCycles == DEREF_EXTRA_CYC_W)
        else $error("indirection time penalty wrong");
    AST_DEREF_STALL: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.ackAge != 5'h00 && r.ackAge <= DEREF_EXTRA_CYC_W) |-> !done && busy)
        else $error("indirection finished early");
    AST_SINGLE_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.ackAge != 5'h00 && r.ackAge <= DEREF_EXTRA_CYC_W + 5'h01) |-> !memReq)
        else $error("second indirection level seen");
    AST_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (r.state == EAU_IDLE && start && ownFormat) |=> done && bypassed && !memReq)
        else $error("special format not bypassed");
endmodule : eau_unit

// ---- hw/eau_pkg.sv ----
// Shared constants and types for the effective address unit.
package eau_pkg;
    localparam int WORD_W = 16;
    localparam int DISP_W = 8;
    localparam int ADDR_FIELD_W = 11;
    localparam int POST_OFFSET_BIT = 10;
    localparam int DEREF_BIT = 9;
    localparam int PRE_OFFSET_BIT = 8;
    localparam int DISP_LSB = 0;
    localparam int DISP_MSB = 7;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Clock period and the extra time that one indirection costs
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEREF_EXTRA_NS = 900;
    localparam int DEREF_EXTRA_CYC = DEREF_EXTRA_NS / CLK_PERIOD_NS;
    localparam logic [4:0] DEREF_EXTRA_CYC_W = 5'(DEREF_EXTRA_CYC);

    typedef enum logic [1:0] {
        EAU_IDLE = 2'b00,
        EAU_FETCH = 2'b01,
        EAU_WAIT = 2'b10
    } eau_state_t;
endpackage : eau_pkg

// ---- hw/eau_adder.sv ----
// Modulo 2^16 three-term adder for address formation.
`timescale 1ns/1ns
module eau_adder
    import eau_pkg::*;
(
    input wire logic [15:0] termA,
    input wire logic [15:0] termB,
    input wire logic [15:0] termC,
    output logic [15:0] sum
);
    // Carry out of bit 15 is discarded on purpose
    logic [17:0] wide;
    always_comb begin
        wide = {2'b00, termA} + {2'b00, termB} + {2'b00, termC};
        sum = wide[15:0];
    end
endmodule : eau_adder

// ---- sim/eau_mem_model.sv ----
// Memory read partner that answers indirect pointer fetches.
`timescale 1ns/1ns
module eau_mem_model (
    input wire logic ref_clk,
    input wire logic memReq,
    input wire logic [15:0] memAddr,
    input wire logic [1:0] ackDelay,
    output logic memAck,
    output logic [15:0] memData
);
    logic [1:0] waitCnt = 2'h0;
    initial memAck = 1'b0;
    initial memData = 16'h0000;
    // Stored word is a fixed pattern of its address; the bench mirrors it
    always @(posedge ref_clk) begin
        if (memAck) begin
            memAck <= 1'b0;
            memData <= ~memData;
            waitCnt <= 2'h0;
        end else if (memReq && waitCnt >= ackDelay) begin
            memAck <= 1'b1;
            memData <= ~memAddr ^ 16'h0f0f;
        end else begin
            // Idle bus never keeps the last word, so stale reads show up
            memData <= ~memData;
            if (memReq) waitCnt <= waitCnt + 2'h1;
        end
    end
endmodule : eau_mem_model

// ---- sim/effective_address_unit_tb.sv ----
// Self-checking bench for the effective address unit.
`timescale 1ns/1ns
module effective_address_unit_tb;
    import eau_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic ownFormat = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [15:0] instrCounter = 16'h0000;
    logic [15:0] commonAreaReg = 16'h0000;
    logic [15:0] steppingReg = 16'h0000;
    logic [1:0] ackDelay = 2'h0;
    logic [15:0] lastEa = WORD_RESET;
    logic memReq, memAck, busy, done, bypassed;
    logic [15:0] memAddr, memData, effAddr;
    logic [4:0] extraCycles;
    int nErrors = 0;
    int checksDone = 0;
    always #25 ref_clk = ~ref_clk;
    eau_unit dut (.ref_clk(ref_clk), .rst_b(rst_b), .start(start), .instrWord(instrWord),
        .ownFormat(ownFormat), .instrCounter(instrCounter), .commonAreaReg(commonAreaReg),
        .steppingReg(steppingReg), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memData(memData), .busy(busy), .done(done), .effAddr(effAddr),
        .extraCycles(extraCycles), .bypassed(bypassed));
    eau_mem_model mem (.ref_clk(ref_clk), .memReq(memReq), .memAddr(memAddr),
        .ackDelay(ackDelay), .memAck(memAck), .memData(memData));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        checksDone++;
        if (seen !== expd) begin
            nErrors++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask : check
    task automatic finalReport();
        $display("checks=%0d mismatches=%0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finalReport
    // Inputs stay put until done, though the unit samples them all in the start cycle
    task automatic runOne(input logic [15:0] iw, input logic own);
        int n;
        int ea;
        logic [15:0] expEa;
        instrWord = iw;
        ownFormat = own;
        ackDelay = 2'($urandom_range(3));
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        ea = iw[8] ? commonAreaReg : instrCounter;
        ea = (ea + int'($signed(iw[7:0]))) & 32'h0000_ffff;
        if (iw[9]) ea = (~ea ^ 32'h0000_0f0f) & 32'h0000_ffff;
        if (iw[10]) ea = ea + steppingReg;
        expEa = own ? lastEa : 16'(ea);
        check({15'h0000, done}, 16'h0001);
        check(effAddr, expEa);
        check({15'h0000, bypassed}, {15'h0000, own});
        check({15'h0000, busy}, 16'h0000);
        if (!own) begin
            check({11'h000, extraCycles}, iw[9] ? 16'h0012 : 16'h0000);
            check({15'h0000, n > 18}, {15'h0000, iw[9]});
            lastEa = expEa;
        end
        @(negedge ref_clk);
        $display("test iw=%h own=%0d finished", iw, own);
    endtask : runOne
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        void'($urandom(10));
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        for (int it = 0; it < 6; it++) begin
            for (int m = 0; m < 8; m++) begin
                // Extreme displacements first, then an all-ones wrap case
                d = (it == 0) ? 8'h80 : (it == 1) ? 8'h7f : 8'($urandom);
                instrCounter = (it == 2) ? 16'hffff : 16'($urandom);
                commonAreaReg = (it == 2) ? 16'hffff : 16'($urandom);
                steppingReg = (it == 2) ? 16'hffff : 16'($urandom);
                runOne({5'($urandom), 3'(m), d}, 1'b0);
            end
            runOne(16'($urandom), 1'b1);
        end
        finalReport();
    end
    initial begin
        #(50 * 5000);
        nErrors++;
        finalReport();
    end
endmodule : effective_address_unit_tb
